// ### rtl/option_byte_pkg.sv
package option_byte_pkg;
    // ------------------------------------------------------------
    // storage map
    // ------------------------------------------------------------
    // word index of the high option byte in the store
    localparam logic [3:0] OPT_HIGH_IDX = 4'hF;
    // erased value of every stored byte
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // high option byte field positions
    // ------------------------------------------------------------
    localparam int STARTUP_CLOCK_SELECT_MSB = 7;
    localparam int STARTUP_CLOCK_SELECT_LSB = 6;
    localparam int RSVD_ONE_BIT = 5;
    localparam int RSVD_ZERO_BIT = 4;
    localparam int LVD_MSB = 3;
    localparam int LVD_LSB = 2;
    localparam int WDG_TYPE_BIT = 1;
    localparam int WATCHDOG_HALT_RESET_BIT = 0;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    // erased (default) clock field picks the internal rc
    localparam logic [1:0] STARTUP_CLOCK_SELECT_INTERNAL_RC = 2'h3;
    // lvd field code that keeps the detector off
    localparam logic [1:0] LVD_DISABLED = 2'h3;

    // ------------------------------------------------------------
    // boot timing after reset release
    // ------------------------------------------------------------
    // cycles until the pin synchroniser holds a true sample
    localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h2;

    // boot sequencer states
    typedef enum logic [1:0] {
        BOOT_WAIT = 2'b00,
        BOOT_LATCH = 2'b01,
        BOOT_RUN = 2'b10
    } boot_state_type;
endpackage : option_byte_pkg

// ### rtl/option_store.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// non-volatile byte store, registered read
// ------------------------------------------------------------
module option_store #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic por,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    // contents; only power-on clears them, never the system reset
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // write port, power-on leaves every byte erased
    // erased all ones
    always_ff @(posedge mclk or posedge por) begin
        if (por) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem_r[i] <= DW'(option_byte_pkg::ERASED_BYTE);
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // read port, one cycle of latency
    always_ff @(posedge mclk or posedge por) begin
        if (por) begin
            rd_data <= DW'(option_byte_pkg::ERASED_BYTE);
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : option_store

// ### rtl/option_byte_config.sv
`timescale 1ns/1ps
module option_byte_config #(
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    input wire logic incircuit_prog_clock_pin,
    input wire logic ext_irq_pin,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [AW-1:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic sw_wdg_enable,
    input wire logic halt_entry,
    output logic [7:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_mode,
    output logic config_valid,
    output logic [1:0] startup_clock_select,
    output logic startup_from_rc,
    output logic lvd_enable,
    output logic [1:0] lvd_threshold,
    output logic watchdog_activation_type,
    output logic watchdog_halt_reset,
    output logic watchdog_running,
    output logic halt_reset_req,
    output logic ext_irq_event,
    output logic reserved_err
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic icc_s1_r; // first stage, read only by second
    logic icc_s2_r; // synchronised programming clock pin
    logic irq_s1_r; // first stage, read only by second
    logic irq_s2_r; // synchronised interrupt pin
    logic irq_s3_r; // previous sample for edge detect
    logic [1:0] boot_cnt_r; // cycles since reset release
    option_byte_pkg::boot_state_type boot_state_r;
    logic sw_wdg_on_r; // software enable, sticky until reset
    logic store_wr; // write into the store
    logic [AW-1:0] store_rd_addr; // store read address
    logic [7:0] store_rd_data; // registered store output
    logic opt_access; // access targets the option byte
    logic run; // configuration in force

    assign run = (boot_state_r == option_byte_pkg::BOOT_RUN);
    assign opt_access = (prog_addr == AW'(option_byte_pkg::OPT_HIGH_IDX));

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pin idles high; resetting to one avoids a false mode entry
    // pulled high default
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            icc_s1_r <= 1'b1;
            icc_s2_r <= 1'b1;
        end else begin
            icc_s1_r <= incircuit_prog_clock_pin;
            icc_s2_r <= icc_s1_r;
        end
    end

    // interrupt pin, two stages plus one for the edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_s3_r <= 1'b0;
        end else begin
            irq_s1_r <= ext_irq_pin;
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
        end
    end

    // rising edge becomes a one-cycle event
    // pulse edge detect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_irq_event <= 1'b0;
        end else begin
            ext_irq_event <= irq_s2_r & ~irq_s3_r;
        end
    end

    // ------------------------------------------------------------
    // boot sequencer
    // ------------------------------------------------------------
    // waits for the synchroniser, latches once, then runs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_cnt_r <= 2'h0;
            boot_state_r <= option_byte_pkg::BOOT_WAIT;
        end else begin
            case (boot_state_r)
                option_byte_pkg::BOOT_WAIT: begin
                    boot_cnt_r <= boot_cnt_r + 2'h1;
                    if (boot_cnt_r == option_byte_pkg::BOOT_SYNC_CYCLES - 2'h1) begin
                        boot_state_r <= option_byte_pkg::BOOT_LATCH;
                    end
                end
                option_byte_pkg::BOOT_LATCH: begin
                    boot_state_r <= option_byte_pkg::BOOT_RUN;
                end
                option_byte_pkg::BOOT_RUN: begin
                    boot_state_r <= option_byte_pkg::BOOT_RUN;
                end
                default: begin
                    boot_state_r <= option_byte_pkg::BOOT_WAIT;
                end
            endcase
        end
    end

    // mode chosen only at boot; pin low then means tool present
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prog_mode <= 1'b0;
        end else if (boot_state_r == option_byte_pkg::BOOT_LATCH) begin
            prog_mode <= ~icc_s2_r;
        end
    end

    // ------------------------------------------------------------
    // configuration latch
    // ------------------------------------------------------------
    // one snapshot per reset; later writes wait for the next one
    // latch once, hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            config_valid <= 1'b0;
            startup_clock_select <= option_byte_pkg::STARTUP_CLOCK_SELECT_INTERNAL_RC;
            startup_from_rc <= 1'b1;
            lvd_enable <= 1'b0;
            lvd_threshold <= option_byte_pkg::LVD_DISABLED;
            watchdog_activation_type <= 1'b1;
            watchdog_halt_reset <= 1'b0;
        end else if (boot_state_r == option_byte_pkg::BOOT_LATCH) begin
            config_valid <= 1'b1;
            startup_clock_select <= store_rd_data[option_byte_pkg::STARTUP_CLOCK_SELECT_MSB:option_byte_pkg::STARTUP_CLOCK_SELECT_LSB];
            startup_from_rc <= (store_rd_data[option_byte_pkg::STARTUP_CLOCK_SELECT_MSB:option_byte_pkg::STARTUP_CLOCK_SELECT_LSB]
                                == option_byte_pkg::STARTUP_CLOCK_SELECT_INTERNAL_RC);
            lvd_threshold <= store_rd_data[option_byte_pkg::LVD_MSB:option_byte_pkg::LVD_LSB];
            lvd_enable <= (store_rd_data[option_byte_pkg::LVD_MSB:option_byte_pkg::LVD_LSB]
                           != option_byte_pkg::LVD_DISABLED);
            watchdog_activation_type <= store_rd_data[option_byte_pkg::WDG_TYPE_BIT];
            watchdog_halt_reset <= store_rd_data[option_byte_pkg::WATCHDOG_HALT_RESET_BIT];
        end
    end

    // ------------------------------------------------------------
    // watchdog and halt
    // ------------------------------------------------------------
    // software enable only counts in software mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sw_wdg_on_r <= 1'b0;
        end else if (run && sw_wdg_enable && watchdog_activation_type) begin
            sw_wdg_on_r <= 1'b1;
        end
    end

    // hardware type runs from one cycle after config is in force
    // hardware always on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_running <= 1'b0;
        end else begin
            watchdog_running <= run & (~watchdog_activation_type | sw_wdg_on_r |
                                       (sw_wdg_enable & watchdog_activation_type));
        end
    end

    // halt while the watchdog runs resets only if the bit is one
    // halt reset request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            halt_reset_req <= 1'b0;
        end else begin
            halt_reset_req <= run & halt_entry & watchdog_running & watchdog_halt_reset;
        end
    end

    // ------------------------------------------------------------
    // programming port
    // ------------------------------------------------------------
    // outside programming mode the store is not written and is read only at the option byte
    // gate by mode
    assign store_wr = prog_wr & prog_mode & run;
    assign store_rd_addr = (prog_rd & prog_mode & run) ? prog_addr : AW'(option_byte_pkg::OPT_HIGH_IDX);

    // read answer one cycle after the request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prog_rvalid <= 1'b0;
        end else begin
            prog_rvalid <= prog_rd & prog_mode & run & ~prog_wr;
        end
    end

    // reserved bits are the tool's duty; a bad write is only flagged
    // bit 5 one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reserved_err <= 1'b0;
        end else begin
            reserved_err <= store_wr & opt_access &
                            (~prog_wdata[option_byte_pkg::RSVD_ONE_BIT] | prog_wdata[option_byte_pkg::RSVD_ZERO_BIT]);
        end
    end

    // byte store; its read register feeds prog_rdata directly
    option_store #(
        .AW(AW),
        .DW(8)
    ) u_store (
        .mclk(mclk),
        .por(por),
        .wr_en(store_wr),
        .wr_addr(prog_addr),
        .wr_data(prog_wdata),
        .rd_addr(store_rd_addr),
        .rd_data(store_rd_data)
    );
    assign prog_rdata = store_rd_data;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [1:0] startup_clock_select_field; // helper view of the stored clock field
    logic [1:0] lvd_field; // helper view of the stored lvd field
    assign startup_clock_select_field = store_rd_data[option_byte_pkg::STARTUP_CLOCK_SELECT_MSB:option_byte_pkg::STARTUP_CLOCK_SELECT_LSB];
    assign lvd_field = store_rd_data[option_byte_pkg::LVD_MSB:option_byte_pkg::LVD_LSB];

    sequence s_halt_armed;
        run && halt_entry && watchdog_running && watchdog_halt_reset;
    endsequence
    sequence s_halt_safe;
        halt_entry && !watchdog_halt_reset;
    endsequence

    property p_no_read_outside_prog;
        prog_rd && !prog_mode |=> !prog_rvalid;
    endproperty
    a_no_read_outside_prog: assert property (p_no_read_outside_prog) else $error("read answered outside programming");

    property p_clock_latched;
        $rose(config_valid) |-> startup_clock_select == $past(startup_clock_select_field);
    endproperty
    a_clock_latched: assert property (p_clock_latched) else $error("clock field not latched");

    property p_rc_default;
        config_valid && startup_clock_select == option_byte_pkg::STARTUP_CLOCK_SELECT_INTERNAL_RC |-> startup_from_rc;
    endproperty
    a_rc_default: assert property (p_rc_default) else $error("default clock not internal rc");

    property p_lvd_latched;
        $rose(config_valid) |-> lvd_threshold == $past(lvd_field)
            && lvd_enable == ($past(lvd_field) != option_byte_pkg::LVD_DISABLED);
    endproperty
    a_lvd_latched: assert property (p_lvd_latched) else $error("lvd selection wrong");

    property p_hw_watchdog;
        run && !watchdog_activation_type |=> watchdog_running;
    endproperty
    a_hw_watchdog: assert property (p_hw_watchdog) else $error("hardware watchdog not running");

    property p_halt_reset;
        s_halt_armed |=> halt_reset_req;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halt reset not requested");

    property p_halt_no_reset;
        s_halt_safe |=> !halt_reset_req;
    endproperty
    a_halt_no_reset: assert property (p_halt_no_reset) else $error("halt reset without option");

    property p_irq_event;
        irq_s2_r && !irq_s3_r |=> ext_irq_event ##1 !ext_irq_event;
    endproperty
    a_irq_event: assert property (p_irq_event) else $error("interrupt edge missed");

    property p_config_held;
        config_valid |=> $stable(startup_clock_select) && $stable(lvd_threshold)
            && $stable(watchdog_activation_type) && $stable(watchdog_halt_reset) && $stable(prog_mode);
    endproperty
    a_config_held: assert property (p_config_held) else $error("configuration changed after latch");

    property p_boot_time;
        $fell(rst) |-> !config_valid[*3] ##1 config_valid;
    endproperty
    a_boot_time: assert property (@(posedge mclk) p_boot_time) else $error("config not valid in time");
endmodule : option_byte_config

// ### verification/prog_tool_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// programming tool model
// ------------------------------------------------------------
module prog_tool_model (
    input wire logic mclk,
    input wire logic [7:0] prog_rdata,
    input wire logic prog_rvalid,
    output logic prog_wr,
    output logic prog_rd,
    output logic [3:0] prog_addr,
    output logic [7:0] prog_wdata,
    output logic incircuit_prog_clock_pin
);
    // idle bus, pin at its pulled level
    initial begin
        prog_wr = 1'b0;
        prog_rd = 1'b0;
        prog_addr = 4'h0;
        prog_wdata = 8'h00;
        incircuit_prog_clock_pin = 1'b1;
    end

    // pin pulled high
    // low only while the tool claims programming mode
    task automatic hold_pin(input logic level);
        incircuit_prog_clock_pin = level;
    endtask : hold_pin

    // reserved bits as handed
    // one byte write; released lines show the inverse, not a stale copy
    task automatic write_byte(input logic [3:0] addr, input logic [7:0] data);
        @(negedge mclk);
        prog_addr = addr;
        prog_wdata = data;
        prog_wr = 1'b1;
        @(negedge mclk);
        prog_wr = 1'b0;
        prog_addr = ~addr;
        prog_wdata = ~data;
    endtask : write_byte

    // one byte read; address held until the answer is taken
    // valid stands a single cycle, so take it before the strobe drops
    task automatic read_byte(input logic [3:0] addr, output logic [7:0] data, output logic valid);
        @(negedge mclk);
        prog_addr = addr;
        prog_rd = 1'b1;
        @(negedge mclk);
        data = prog_rdata;
        valid = prog_rvalid;
        prog_rd = 1'b0;
        prog_addr = ~addr;
    endtask : read_byte
endmodule : prog_tool_model

// ### verification/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// option byte bench
// ------------------------------------------------------------
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic ext_irq_pin = 1'b0;
    logic sw_wdg_enable = 1'b0;
    logic halt_entry = 1'b0;
    logic pin;
    logic prog_wr;
    logic prog_rd;
    logic [3:0] prog_addr;
    logic [7:0] prog_wdata;
    logic [7:0] prog_rdata;
    logic prog_rvalid;
    logic prog_mode;
    logic config_valid;
    logic [1:0] startup_clock_select;
    logic startup_from_rc;
    logic lvd_enable;
    logic [1:0] lvd_threshold;
    logic watchdog_activation_type;
    logic watchdog_halt_reset;
    logic watchdog_running;
    logic halt_reset_req;
    logic ext_irq_event;
    logic reserved_err;
    int n_errors = 0;
    int compares = 0;
    // reference store, survives rst like the real one
    int mem [16];
    int ob;
    int a;
    int seen;
    int lat; // option byte in the store at the last reset
    logic [7:0] rd;
    logic rv;

    // 20 MHz clock
    always #25 mclk = ~mclk;

    option_byte_config #(.AW(4)) u_dut (.mclk(mclk), .rst(rst), .por(por), .incircuit_prog_clock_pin(pin),
        .ext_irq_pin(ext_irq_pin), .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .sw_wdg_enable(sw_wdg_enable), .halt_entry(halt_entry),
        .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .prog_mode(prog_mode), .config_valid(config_valid),
        .startup_clock_select(startup_clock_select), .startup_from_rc(startup_from_rc), .lvd_enable(lvd_enable),
        .lvd_threshold(lvd_threshold), .watchdog_activation_type(watchdog_activation_type),
        .watchdog_halt_reset(watchdog_halt_reset), .watchdog_running(watchdog_running),
        .halt_reset_req(halt_reset_req), .ext_irq_event(ext_irq_event), .reserved_err(reserved_err));

    prog_tool_model u_tool (.mclk(mclk), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .prog_wr(prog_wr),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_wdata(prog_wdata), .incircuit_prog_clock_pin(pin));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // kinds of result: stored bytes, config fields, pulse counts
    task automatic check_data(input string what, input int exp, input logic [7:0] got);
        cmp(what, 8'(exp), got);
    endtask : check_data

    task automatic check_field(input string what, input int exp, input logic [1:0] got);
        cmp(what, 8'(exp), {6'h00, got});
    endtask : check_field

    task automatic check_count(input string what, input int exp, input int got);
        cmp(what, 8'(exp), 8'(got));
    endtask : check_count

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // counts high cycles of one pulse output over six samples
    task automatic count_flag(input int sel, output int n);
        n = 0;
        repeat (6) begin
            case (sel)
                0: n += int'(reserved_err === 1'b1);
                1: n += int'(halt_reset_req === 1'b1);
                default: n += int'(ext_irq_event === 1'b1);
            endcase
            @(negedge mclk);
        end
    endtask : count_flag

    // reset with the pin chosen; bounded wait for the latch
    task automatic do_reset(input logic prog);
        int k;
        rst = 1'b1;
        lat = mem[15];
        u_tool.hold_pin(~prog);
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        por = 1'b0;
        k = 0;
        while (config_valid !== 1'b1 && k < 10) begin
            @(negedge mclk);
            k++;
        end
        if (k == 10) begin
            n_errors++;
            print_verdict();
        end
        @(negedge mclk);
        check_field("prog_mode", prog, {1'b0, prog_mode}); // mode from pin
    endtask : do_reset

    task automatic check_config();
        check_field("startup_clock_select", (ob >> 6) & 3, startup_clock_select); // clock field
        check_field("startup_from_rc", ((ob >> 6) & 3) == 3, {1'b0, startup_from_rc}); // rc default
        check_field("lvd_enable", ((ob >> 2) & 3) != 3, {1'b0, lvd_enable}); // detector on
        check_field("lvd_threshold", (ob >> 2) & 3, lvd_threshold); // threshold
        check_field("watchdog_activation_type", (ob >> 1) & 1, {1'b0, watchdog_activation_type}); // type
        check_field("watchdog_halt_reset", ob & 1, {1'b0, watchdog_halt_reset}); // halt bit
    endtask : check_config

    task automatic halt_pulse(input int exp);
        halt_entry = 1'b1;
        @(negedge mclk);
        halt_entry = 1'b0;
        count_flag(1, seen);
        check_count("halt_reset_req", exp, seen); // halt reset
    endtask : halt_pulse

    // normal run: fields, watchdog, halt, interrupt, then still held
    task automatic run_checks();
        ob = mem[15];
        check_config();
        check_field("watchdog_running", ((ob >> 1) & 1) == 0, {1'b0, watchdog_running}); // hardware runs
        halt_pulse((((ob >> 1) & 1) == 0) && (ob & 1));
        sw_wdg_enable = 1'b1;
        @(negedge mclk);
        sw_wdg_enable = 1'b0;
        @(negedge mclk);
        check_field("watchdog_running", 1, {1'b0, watchdog_running}); // software start
        halt_pulse(ob & 1);
        ext_irq_pin = 1'b1;
        @(negedge mclk);
        ext_irq_pin = 1'b0;
        count_flag(2, seen);
        check_count("ext_irq_event", 1, seen); // pulse seen once
        check_config(); // config held
    endtask : run_checks

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC9A1));
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'hFF;
        end
        do_reset(1'b0);
        run_checks(); // erased config
        u_tool.read_byte(4'hF, rd, rv);
        check_field("prog_rvalid", 0, {1'b0, rv}); // normal read refused
        u_tool.write_byte(4'hF, 8'h2A);
        do_reset(1'b1);
        u_tool.read_byte(4'hF, rd, rv);
        check_data("option byte", mem[15], rd); // normal write refused
        check_field("prog_rvalid", 1, {1'b0, rv}); // read answered
        a = $urandom_range(14, 0);
        u_tool.read_byte(a[3:0], rd, rv);
        check_data("program byte", 8'hFF, rd); // erased memory
        // deliberately wrong reserved patterns, one bit at a time
        u_tool.write_byte(4'hF, 8'h00);
        count_flag(0, seen);
        check_count("reserved_err", 1, seen); // bit 5 clear flagged
        u_tool.write_byte(4'hF, 8'h30);
        mem[15] = 8'h30;
        count_flag(0, seen);
        check_count("reserved_err", 1, seen); // bit 4 set flagged
        for (int i = 0; i < 4; i++) begin
            ob = (($urandom & 8'hCF) | 8'h20) & 8'h33;
            // bit 5 set, bit 4 clear
            ob = ob | (i << 6) | ((3 - i) << 2);
            u_tool.write_byte(4'hF, 8'(ob));
            count_flag(0, seen);
            check_count("reserved_err", 0, seen); // clean write
            mem[15] = ob;
            a = $urandom_range(14, 0);
            mem[a] = $urandom_range(255, 0);
            u_tool.write_byte(a[3:0], 8'(mem[a]));
            u_tool.read_byte(4'hF, rd, rv);
            check_data("option byte", mem[15], rd); // programmed byte
            u_tool.read_byte(a[3:0], rd, rv);
            check_data("program byte", mem[a], rd); // programmed byte
            ob = lat;
            check_config(); // new byte waits for reset
            do_reset(1'b0);
            run_checks();
            do_reset(1'b1);
        end
        print_verdict();
    end
endmodule : testbench
